// ### logic/cdls_regs.svh
// Register offsets, field positions, reset values and timing counts of the sequencer.
`ifndef CDLS_REGS_SVH
`define CDLS_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define CDLS_CLK_HZ 40000000
`define CDLS_TICK_US 1000
`define CDLS_TICK_CYC ((`CDLS_CLK_HZ / 1000000) * `CDLS_TICK_US)
`define CDLS_DLY_UNIT_MS 10
`define CDLS_DLY_UNIT_TICKS ((`CDLS_DLY_UNIT_MS * 1000) / `CDLS_TICK_US)

// ****************************************
// Register offsets
// ****************************************
`define CDLS_OFF_CTRL 8'h00
`define CDLS_OFF_STATUS 8'h04
`define CDLS_OFF_ENTRY_IDX 8'h08
`define CDLS_OFF_ENTRY_LO 8'h0C
`define CDLS_OFF_ENTRY_HI 8'h10
`define CDLS_OFF_PROFILE 8'h14
`define CDLS_OFF_DEV_LIM 8'h18
`define CDLS_OFF_DSEL_LO 8'h1C
`define CDLS_OFF_DSEL_HI 8'h20
`define CDLS_OFF_CMD_POS 8'h24

// ****************************************
// Field positions
// ****************************************
`define CDLS_CTRL_ACLR 0
`define CDLS_A_SPD_MSB 15
`define CDLS_A_SPD_LSB 0
`define CDLS_A_KIND_MSB 18
`define CDLS_A_KIND_LSB 16
`define CDLS_A_LINK_MSB 21
`define CDLS_A_LINK_LSB 20
`define CDLS_A_NEXT_MSB 30
`define CDLS_A_NEXT_LSB 22
`define CDLS_B_POS_MSB 19
`define CDLS_B_POS_LSB 0
`define CDLS_B_DLY_MSB 31
`define CDLS_B_DLY_LSB 20

// ****************************************
// Reset values and field codes
// ****************************************
`define CDLS_RST_START_SPD 16'h0064
`define CDLS_RST_ACCEL 16'h0010
`define CDLS_RST_DEV_LIM 24'h001000
`define CDLS_RST_ENTRY_A 32'h7FC00000
`define CDLS_RST_ENTRY_B 32'h00000000
`define CDLS_NEXT_STOP 9'h100
`define CDLS_NEXT_P2 9'h1FE
`define CDLS_NEXT_P1 9'h1FF

`endif

// ### logic/cdls_pkg.sv
// Types shared by the stored-data sequencer.
`default_nettype none
package cdls_pkg;
   // Operation kind as stored in an entry.
   typedef enum logic [2:0] {
      K_POS = 3'h0,
      K_POS_PUSH = 3'h1,
      K_CONT_POS = 3'h2,
      K_CONT_SPD = 3'h3,
      K_CONT_PUSH = 3'h4,
      K_CONT_TRQ = 3'h5
   } cdls_kind_t;
   // Link mode as stored in an entry.
   typedef enum logic [1:0] {
      LINK_NONE = 2'h0,
      LINK_MANUAL = 2'h1,
      LINK_AUTO = 2'h2,
      LINK_CONT = 2'h3
   } cdls_link_t;
   // Sequencer states.
   typedef enum logic [3:0] {
      S_INIT, S_IDLE, S_FETCH, S_LOAD, S_RUN, S_STOP, S_DELAY, S_WAIT, S_ALARM
   } cdls_state_t;
   // What follows once the motor is at rest.
   typedef enum logic [1:0] {A_END, A_WAIT, A_DELAY} cdls_after_t;
endpackage
`default_nettype wire

// ### logic/cdls_op_mem.sv
// Operation data table: two registered read ports, one half-word write port.
`timescale 1ns/1ps
`default_nettype none
module cdls_op_mem #(
   parameter int unsigned AW = 8,  // Address width.
   parameter int unsigned DW = 64  // Entry width.
) (
   input wire logic clk_i,  // Clock.
   input wire logic we_lo_i,  // Write lower half.
   input wire logic we_hi_i,  // Write upper half.
   input wire logic [AW-1:0] waddr_i,  // Write address.
   input wire logic [DW-1:0] wdata_i,  // Write data.
   input wire logic [AW-1:0] seq_addr_i,  // Sequencer read address.
   output logic [DW-1:0] seq_q_o,  // Sequencer read data.
   input wire logic [AW-1:0] bus_addr_i,  // Bus read address.
   output logic [DW-1:0] bus_q_o  // Bus read data, write-through.
);
   localparam int unsigned HW = DW / 2;

   // ****************************************
   // Checks
   // ****************************************
   if (DW % 2 != 0 || AW < 1) begin : g_bad
      $error("cdls_op_mem: width must be even and address nonzero");
   end

   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] merged;

   // Merge the written half so a read of the same entry sees it at once.
   always_comb begin
      merged = mem[bus_addr_i];
      if (waddr_i == bus_addr_i && we_lo_i) begin
         merged[HW-1:0] = wdata_i[HW-1:0];
      end
      if (waddr_i == bus_addr_i && we_hi_i) begin
         merged[DW-1:HW] = wdata_i[DW-1:HW];
      end
   end

   // Writes land in the addressed half.
   always_ff @(posedge clk_i) begin
      if (we_lo_i) begin
         mem[waddr_i][HW-1:0] <= wdata_i[HW-1:0];
      end
      if (we_hi_i) begin
         mem[waddr_i][DW-1:HW] <= wdata_i[DW-1:HW];
      end
   end

   // Both read ports come out of registers.
   always_ff @(posedge clk_i) begin
      seq_q_o <= mem[seq_addr_i];
      bus_q_o <= merged;
   end
endmodule
`default_nettype wire

// ### logic/cdls_seq.sv
// Stored-data operation sequencer with entry linking and a register port.
`timescale 1ns/1ps
`default_nettype none
`include "cdls_regs.svh"

// Notes on behaviour
// - Continuous: positive speed forward, negative reverse.
// - Continuous target is the start position.
// - Torque variant jumps straight to speed.
// - Other continuous variants ramp from starting speed.
// - Position control raises overload or deviation alarm.
// - Speed control clamps deviation, overload alarm only.
// - Continuous push and torque press on without alarm.
// - Start drops ready and launches selected entry.
// - Stop decelerates position, speed, continuous push variants.
// - Stop halts torque variant at once.
// - Ready returns once the motor rests.
// - Chain start from data or direct select.
// - Positioning advances on target, next or jump.
// - Continuous advances only on next or jump.
// - Link field 0 none,1 manual,2 auto,3 continuous.
// - Next field -256 stop,-2,-1, or absolute.
// - Unlinked entry runs once then ends.
// - Sequence launch runs the linked next entry.
// - Manual entry done raises sequence busy waiting.
// - Sequence launch when not busy runs selection.
// - Automatic link waits delay, then starts next.
// - Continuous form link keeps motor moving, unless target reached.
// - Chain finished drops busy, raises ready.
module cdls_seq
   import cdls_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `CDLS_TICK_CYC  // Clock cycles per motion tick.
) (
   input wire logic core_clk_i,  // Clock.
   input wire logic rst_i,  // Synchronous reset, active high.
   input wire logic [7:0] addr_i,  // Register byte address.
   input wire logic [31:0] wr_data_i,  // Register write data.
   input wire logic wr_i,  // Write strobe.
   input wire logic rd_i,  // Read strobe.
   output logic [31:0] rd_data_o,  // Read data, cycle after strobe.
   input wire logic start_i,  // Start request.
   input wire logic stop_i,  // Stop request, level.
   input wire logic next_i,  // Advance to next entry.
   input wire logic seq_launch_i,  // Sequence launch.
   input wire logic event_jump_i,  // Event jump.
   input wire logic [7:0] data_sel_i,  // Data select inputs.
   input wire logic [7:0] direct_sel_i,  // Direct select inputs.
   input wire logic [23:0] fb_pos_i,  // Feedback position.
   input wire logic overload_i,  // Load above motor torque.
   output logic ready_o,  // Ready for a start.
   output logic seq_busy_o,  // Sequence busy.
   output logic motor_dir_o,  // High for reverse.
   output logic [15:0] cmd_speed_o,  // Command speed magnitude.
   output logic signed [23:0] cmd_pos_o,  // Command position.
   output logic alarm_overload_o,  // Overload alarm.
   output logic alarm_deviation_o,  // Excessive deviation alarm.
   output logic [7:0] active_entry_o  // Entry being run.
);
   // ****************************************
   // Checks and helpers
   // ****************************************
   if (TICK_CYCLES < 1 || TICK_CYCLES > 1048576) begin : g_bad
      $error("cdls_seq: TICK_CYCLES out of range");
   end

   function automatic logic [15:0] abs16(input logic [15:0] v);
      return v[15] ? 16'(-v) : v;
   endfunction

   function automatic logic is_rect(input cdls_kind_t k);
      return k == K_CONT_TRQ || k == K_POS_PUSH;
   endfunction

   function automatic logic is_cont(input cdls_kind_t k);
      return k != K_POS && k != K_POS_PUSH;
   endfunction

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

   // Decodes the next-entry field against the current entry.
   function automatic logic [8:0] next_of(input logic [7:0] cur, input logic [8:0] f);
      if (f == `CDLS_NEXT_P2) begin
         return {1'b1, 8'(cur + 8'h02)};
      end else if (f == `CDLS_NEXT_P1) begin
         return {1'b1, 8'(cur + 8'h01)};
      end else begin
         return {~f[8], f[7:0]};
      end
   endfunction

   // ****************************************
   // Tick divider and input edges
   // ****************************************
   logic [19:0] tick_cnt;
   logic tick;
   logic start_q, next_q, launch_q, jump_q;
   logic [7:0] dsel_q;
   logic start_rise, next_rise, launch_rise, jump_rise;
   logic [7:0] dsel_rise;

   assign tick = (tick_cnt == 20'(TICK_CYCLES - 1));

   // Motion steps once per tick.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || tick) begin
         tick_cnt <= 20'h00000;
      end else begin
         tick_cnt <= tick_cnt + 20'h00001;
      end
   end

   // Previous input levels, so a held level launches only once.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         start_q <= 1'b0;
         next_q <= 1'b0;
         launch_q <= 1'b0;
         jump_q <= 1'b0;
         dsel_q <= 8'h00;
      end else begin
         start_q <= start_i;
         next_q <= next_i;
         launch_q <= seq_launch_i;
         jump_q <= event_jump_i;
         dsel_q <= direct_sel_i;
      end
   end

   assign start_rise = start_i & ~start_q;
   assign next_rise = next_i & ~next_q;
   assign launch_rise = seq_launch_i & ~launch_q;
   assign jump_rise = event_jump_i & ~jump_q;
   assign dsel_rise = direct_sel_i & ~dsel_q;

   // ****************************************
   // Registers
   // ****************************************
   cdls_state_t state;
   logic [7:0] entry_idx, next_entry_idx, init_idx;
   logic [15:0] start_spd, accel;
   logic [23:0] dev_lim;
   logic [63:0] dsel_map;
   logic alarm_clr;
   logic [63:0] seq_q, bus_q;
   logic mem_we_lo, mem_we_hi;

   assign alarm_clr = wr_i && addr_i == `CDLS_OFF_CTRL && wr_data_i[`CDLS_CTRL_ACLR];
   assign next_entry_idx = (wr_i && addr_i == `CDLS_OFF_ENTRY_IDX) ? wr_data_i[7:0] : entry_idx;
   assign mem_we_lo = (state == S_INIT) || (wr_i && addr_i == `CDLS_OFF_ENTRY_LO);
   assign mem_we_hi = (state == S_INIT) || (wr_i && addr_i == `CDLS_OFF_ENTRY_HI);

   // Software settings: table index, motion profile, deviation limit, direct map.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         entry_idx <= 8'h00;
         start_spd <= `CDLS_RST_START_SPD;
         accel <= `CDLS_RST_ACCEL;
         dev_lim <= `CDLS_RST_DEV_LIM;
         dsel_map <= 64'h0706050403020100;
      end else if (wr_i) begin
         unique case (addr_i)
            `CDLS_OFF_ENTRY_IDX: entry_idx <= wr_data_i[7:0];
            `CDLS_OFF_PROFILE: begin
               start_spd <= wr_data_i[15:0];
               accel <= wr_data_i[31:16];
            end
            `CDLS_OFF_DEV_LIM: dev_lim <= wr_data_i[23:0];
            `CDLS_OFF_DSEL_LO: dsel_map[31:0] <= wr_data_i;
            `CDLS_OFF_DSEL_HI: dsel_map[63:32] <= wr_data_i;
            default: ;
         endcase
      end
   end

   // Read answers; unmapped addresses read zero.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_data_o <= 32'h00000000;
      end else if (rd_i) begin
         unique case (addr_i)
            `CDLS_OFF_STATUS: rd_data_o <= {16'h0000, active_entry_o, 4'(state),
               alarm_deviation_o, alarm_overload_o, seq_busy_o, ready_o};
            `CDLS_OFF_ENTRY_IDX: rd_data_o <= {24'h000000, entry_idx};
            `CDLS_OFF_ENTRY_LO: rd_data_o <= bus_q[31:0];
            `CDLS_OFF_ENTRY_HI: rd_data_o <= bus_q[63:32];
            `CDLS_OFF_PROFILE: rd_data_o <= {accel, start_spd};
            `CDLS_OFF_DEV_LIM: rd_data_o <= {8'h00, dev_lim};
            `CDLS_OFF_DSEL_LO: rd_data_o <= dsel_map[31:0];
            `CDLS_OFF_DSEL_HI: rd_data_o <= dsel_map[63:32];
            `CDLS_OFF_CMD_POS: rd_data_o <= {{8{cmd_pos_o[23]}}, cmd_pos_o};
            default: rd_data_o <= 32'h00000000;
         endcase
      end
   end

   // Table; cleared to link none and next +1 after reset.
   cdls_op_mem #(.AW(8), .DW(64)) u_mem (
      .clk_i(core_clk_i),
      .we_lo_i(mem_we_lo),
      .we_hi_i(mem_we_hi),
      .waddr_i((state == S_INIT) ? init_idx : entry_idx),
      .wdata_i((state == S_INIT) ? {`CDLS_RST_ENTRY_B, `CDLS_RST_ENTRY_A} : {wr_data_i, wr_data_i}),
      .seq_addr_i(active_entry_o),
      .seq_q_o(seq_q),
      .bus_addr_i(next_entry_idx),
      .bus_q_o(bus_q)
   );

   // ****************************************
   // Decode and motion arithmetic
   // ****************************************
   cdls_kind_t kind;
   cdls_link_t link;
   cdls_after_t after;
   logic [8:0] nxt_f;
   logic [7:0] pend;
   logic [11:0] dly_units;
   logic [15:0] tgt_spd, dly, q_spd;
   logic signed [23:0] tgt_pos, step_pos, dev, clamp_pos, q_pos;
   logic [23:0] dev_abs;
   logic dev_over, reached, entry_done, launch_go, moving;
   logic [8:0] nx;
   logic [7:0] launch_idx;

   assign q_spd = seq_q[`CDLS_A_SPD_MSB:`CDLS_A_SPD_LSB];
   assign q_pos = 24'(signed'(seq_q[32+`CDLS_B_POS_MSB:32+`CDLS_B_POS_LSB]));
   assign step_pos = motor_dir_o ? cmd_pos_o - signed'({8'h00, cmd_speed_o}) :
      cmd_pos_o + signed'({8'h00, cmd_speed_o});
   assign dev = cmd_pos_o - signed'(fb_pos_i);
   assign dev_abs = dev[23] ? 24'(-dev) : dev;
   assign dev_over = dev_abs > dev_lim;
   assign clamp_pos = dev[23] ? signed'(fb_pos_i) - signed'(dev_lim) : signed'(fb_pos_i) + signed'(dev_lim);
   assign reached = !is_cont(kind) && tick && (motor_dir_o ? step_pos <= tgt_pos : step_pos >= tgt_pos);
   assign entry_done = reached || next_rise || jump_rise;
   assign nx = next_of(active_entry_o, nxt_f);
   assign moving = state == S_RUN || state == S_STOP;

   // Picks the entry a launch starts from.
   always_comb begin
      launch_go = 1'b0;
      launch_idx = data_sel_i;
      if (start_rise) begin
         launch_go = 1'b1;
      end else if (dsel_rise != 8'h00) begin
         launch_go = 1'b1;
         for (int i = 7; i >= 0; i--) begin
            if (dsel_rise[i]) begin
               launch_idx = dsel_map[8*i +: 8];
            end
         end
      end else if (launch_rise) begin
         launch_go = 1'b1;
         launch_idx = (state == S_WAIT) ? pend : data_sel_i;
      end
   end

   // ****************************************
   // Alarms
   // ****************************************
   // Sticky; an event in the clearing cycle wins over the clear.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         alarm_overload_o <= 1'b0;
         alarm_deviation_o <= 1'b0;
      end else begin
         if (moving && overload_i && (!is_cont(kind) || kind == K_CONT_POS || kind == K_CONT_SPD)) begin
            alarm_overload_o <= 1'b1;
         end else if (alarm_clr) begin
            alarm_overload_o <= 1'b0;
         end
         if (moving && dev_over && (kind == K_POS || kind == K_CONT_POS)) begin
            alarm_deviation_o <= 1'b1;
         end else if (alarm_clr) begin
            alarm_deviation_o <= 1'b0;
         end
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state <= S_INIT;
         init_idx <= 8'h00;
         ready_o <= 1'b0;
         seq_busy_o <= 1'b0;
         active_entry_o <= 8'h00;
         cmd_speed_o <= 16'h0000;
         motor_dir_o <= 1'b0;
         cmd_pos_o <= 24'sh000000;
         kind <= K_POS;
         link <= LINK_NONE;
         nxt_f <= `CDLS_NEXT_P1;
         pend <= 8'h00;
         dly_units <= 12'h000;
         dly <= 16'h0000;
         tgt_spd <= 16'h0000;
         tgt_pos <= 24'sh000000;
         after <= A_END;
      end else if ((alarm_overload_o || alarm_deviation_o) && state != S_INIT && state != S_ALARM) begin
         // Any alarm halts the motor and drops the sequence.
         cmd_speed_o <= 16'h0000;
         ready_o <= 1'b0;
         seq_busy_o <= 1'b0;
         state <= S_ALARM;
      end else begin
         unique case (state)
            S_INIT: begin
               init_idx <= init_idx + 8'h01;
               if (init_idx == 8'hFF) begin
                  ready_o <= 1'b1;
                  state <= S_IDLE;
               end
            end
            S_IDLE, S_WAIT: begin
               if (launch_go) begin
                  ready_o <= 1'b0;
                  seq_busy_o <= 1'b1;
                  active_entry_o <= launch_idx;
                  cmd_speed_o <= 16'h0000;
                  state <= S_FETCH;
               end else if (state == S_WAIT && stop_i) begin
                  seq_busy_o <= 1'b0;
                  state <= S_IDLE;
               end
            end
            S_FETCH: state <= S_LOAD;
            S_LOAD: begin
               kind <= cdls_kind_t'(seq_q[`CDLS_A_KIND_MSB:`CDLS_A_KIND_LSB]);
               link <= cdls_link_t'(seq_q[`CDLS_A_LINK_MSB:`CDLS_A_LINK_LSB]);
               nxt_f <= seq_q[`CDLS_A_NEXT_MSB:`CDLS_A_NEXT_LSB];
               dly_units <= seq_q[32+`CDLS_B_DLY_MSB:32+`CDLS_B_DLY_LSB];
               tgt_spd <= abs16(q_spd);
               if (is_cont(cdls_kind_t'(seq_q[`CDLS_A_KIND_MSB:`CDLS_A_KIND_LSB]))) begin
                  motor_dir_o <= q_spd[15];
                  tgt_pos <= cmd_pos_o;
               end else begin
                  motor_dir_o <= q_pos < cmd_pos_o;
                  tgt_pos <= q_pos;
               end
               if (is_rect(cdls_kind_t'(seq_q[`CDLS_A_KIND_MSB:`CDLS_A_KIND_LSB]))) begin
                  cmd_speed_o <= abs16(q_spd);
               end else if (cmd_speed_o == 16'h0000) begin
                  cmd_speed_o <= min16(start_spd, abs16(q_spd));
               end
               state <= S_RUN;
            end
            S_RUN: begin
               if (stop_i) begin
                  after <= A_END;
                  state <= S_STOP;
                  if (is_rect(kind)) begin
                     cmd_speed_o <= 16'h0000;
                  end
               end else if (entry_done) begin
                  if (reached) begin
                     cmd_pos_o <= tgt_pos;
                     cmd_speed_o <= 16'h0000;
                  end
                  pend <= nx[7:0];
                  if (link == LINK_CONT && nx[8]) begin
                     active_entry_o <= nx[7:0];
                     state <= S_FETCH;
                  end else begin
                     after <= !nx[8] ? A_END : (link == LINK_MANUAL) ? A_WAIT :
                        (link == LINK_AUTO) ? A_DELAY : A_END;
                     state <= S_STOP;
                  end
               end else if (tick) begin
                  if (!is_rect(kind) && cmd_speed_o < tgt_spd) begin
                     cmd_speed_o <= min16(16'(cmd_speed_o + accel), tgt_spd);
                  end else if (cmd_speed_o > tgt_spd) begin
                     cmd_speed_o <= (is_rect(kind) || cmd_speed_o - tgt_spd < accel) ? tgt_spd :
                        16'(cmd_speed_o - accel);
                  end
                  if (dev_over && kind != K_POS && kind != K_CONT_POS) begin
                     cmd_pos_o <= clamp_pos;
                  end else begin
                     cmd_pos_o <= step_pos;
                  end
               end
            end
            S_STOP: begin
               if (cmd_speed_o == 16'h0000) begin
                  unique case (after)
                     A_END: begin
                        ready_o <= 1'b1;
                        seq_busy_o <= 1'b0;
                        state <= S_IDLE;
                     end
                     A_WAIT: begin
                        ready_o <= 1'b1;
                        seq_busy_o <= 1'b1;
                        state <= S_WAIT;
                     end
                     default: begin
                        dly <= 16'({4'h0, dly_units} * 16'(`CDLS_DLY_UNIT_TICKS));
                        state <= S_DELAY;
                     end
                  endcase
               end else if (is_rect(kind)) begin
                  cmd_speed_o <= 16'h0000;
               end else if (tick) begin
                  cmd_speed_o <= (cmd_speed_o > accel && cmd_speed_o - accel > start_spd) ?
                     16'(cmd_speed_o - accel) : 16'h0000;
                  cmd_pos_o <= step_pos;
               end
            end
            S_DELAY: begin
               if (stop_i) begin
                  ready_o <= 1'b1;
                  seq_busy_o <= 1'b0;
                  state <= S_IDLE;
               end else if (tick) begin
                  if (dly == 16'h0000) begin
                     active_entry_o <= pend;
                     state <= S_FETCH;
                  end else begin
                     dly <= dly - 16'h0001;
                  end
               end
            end
            S_ALARM: begin
               if (!alarm_overload_o && !alarm_deviation_o) begin
                  ready_o <= 1'b1;
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### dv/cdls_seq_checker.sv
// Port assertions for the sequencer.
`timescale 1ns/1ps
`default_nettype none
module cdls_seq_checker (
   input wire logic core_clk_i, // Clock.
   input wire logic rst_i, // Reset.
   input wire logic rd_i, // Read.
   input wire logic [31:0] rd_data_o, // Data.
   input wire logic start_i, // Start.
   input wire logic seq_launch_i, // Launch.
   input wire logic [7:0] data_sel_i, // Select.
   input wire logic ready_o, // Ready.
   input wire logic seq_busy_o, // Busy.
   input wire logic [15:0] cmd_speed_o, // Speed.
   input wire logic alarm_overload_o, // Alarm.
   input wire logic alarm_deviation_o, // Alarm.
   input wire logic [7:0] active_entry_o // Entry.
);
   wire logic al = alarm_overload_o | alarm_deviation_o;  // Either alarm flag is set.
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_start_go: assert property ($rose(start_i) && ready_o && !al |=> !ready_o && seq_busy_o)
      else $error("start not taken");
   a_launch_go: assert property ($rose(seq_launch_i) && ready_o && !al |=> !ready_o && seq_busy_o)
      else $error("launch not taken");
   a_sel_taken: assert property ($rose(start_i) && ready_o && !al |=> active_entry_o == $past(data_sel_i))
      else $error("wrong entry");
   a_alarm_halt: assert property (al |=> !ready_o && !seq_busy_o && cmd_speed_o == 16'h0000)
      else $error("alarm did not halt");
   a_moving_busy: assert property (cmd_speed_o != 16'h0000 |-> seq_busy_o && !ready_o)
      else $error("moving while idle");
   a_busy_rise: assert property ($rose(seq_busy_o) |-> !ready_o)
      else $error("busy rose with ready");
   a_ready_rest: assert property (ready_o |-> cmd_speed_o == 16'h0000)
      else $error("ready while moving");
   a_rd_stands: assert property (!$past(rd_i) |-> $stable(rd_data_o))
      else $error("read data moved");
endmodule
bind cdls_seq cdls_seq_checker cdls_seq_checker_i (.core_clk_i, .rst_i, .rd_i, .rd_data_o, .start_i,
   .seq_launch_i, .data_sel_i, .ready_o, .seq_busy_o, .cmd_speed_o, .alarm_overload_o, .alarm_deviation_o,
   .active_entry_o);
`default_nettype wire

// ### dv/cdls_motor_model.sv
// Motor and load model driving feedback and overload.
`timescale 1ns/1ps
`default_nettype none
module cdls_motor_model (
   input wire logic clk_i, // Clock.
   input wire logic jam_i, // Load blocks shaft.
   input wire logic [23:0] cmd_pos_i, // Command.
   output logic [23:0] fb_pos_o, // Feedback.
   output logic overload_o // Overload.
);
   // The shaft lags the command a cycle; a jam freezes it and overloads.
   always_ff @(posedge clk_i) begin
      if (!jam_i) begin
         fb_pos_o <= cmd_pos_i;
      end
      overload_o <= jam_i;
   end
endmodule
`default_nettype wire

// ### dv/cdls_seq_tb_top.sv
// Bench for the sequencer.
`timescale 1ns/1ps
`default_nettype none
module cdls_seq_tb_top;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, st = 1'b0, sp = 1'b0, sl = 1'b0, jam = 1'b0;
   logic [7:0] adr = 8'h00, sel = 8'h00;
   logic [31:0] wd = 32'h00000000;
   wire logic [31:0] rdat;
   wire logic rdy, busy, dir, ao, ad, ovl;
   wire logic [15:0] spd;
   wire logic [23:0] pos, fb;
   wire logic [7:0] act;
   int fails = 0, total_checks = 0;
   // Clock at 40 MHz.
   initial forever #12.5 clk = ~clk;
   cdls_seq #(.TICK_CYCLES(4)) cdls_seq_i (.core_clk_i(clk), .rst_i(rst), .addr_i(adr), .wr_data_i(wd),
      .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .start_i(st), .stop_i(sp), .next_i(1'b0), .seq_launch_i(sl),
      .event_jump_i(1'b0), .data_sel_i(sel), .direct_sel_i(8'h00), .fb_pos_i(fb), .overload_i(ovl),
      .ready_o(rdy), .seq_busy_o(busy), .motor_dir_o(dir), .cmd_speed_o(spd), .cmd_pos_o(pos),
      .alarm_overload_o(ao), .alarm_deviation_o(ad), .active_entry_o(act));
   cdls_motor_model cdls_motor_model_i (.clk_i(clk), .jam_i(jam), .cmd_pos_i(pos), .fb_pos_o(fb), .overload_o(ovl));
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Waits for ready to reach a level; a hang ends the run.
   task automatic wrdy(input logic v);
      for (int i = 0; i < 4000 && rdy !== v; i++) begin
         @(posedge clk);
         #1;
      end
      if (rdy !== v) begin
         fails++;
         test_done();
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdat, e);
   endtask
   task automatic ent(input logic [7:0] n, input logic [31:0] a, input logic [31:0] b);
      wreg(8'h08, {24'h000000, n});
      wreg(8'h0C, a);
      wreg(8'h10, b);
      rreg(8'h0C, a);
   endtask
   // Host start: ready seen, select, start, release once ready drops.
   task automatic run(input logic [7:0] n);
      wrdy(1'b1);
      sel <= n;
      @(posedge clk);
      st <= 1'b1;
      wrdy(1'b0);
      @(posedge clk);
      st <= 1'b0;
   endtask
   task automatic halt(input logic ramp);
      @(posedge clk);
      sp <= 1'b1;
      cyc(2);
      #1;
      chk(spd != 16'h0000, ramp);
      wrdy(1'b1);
      chk({busy, spd}, 17'h00000);
      @(posedge clk);
      sp <= 1'b0;
   endtask
   task automatic t_def;
      rreg(8'h14, 32'h00100064);
      rreg(8'h1C, 32'h03020100);
      rreg(8'h0C, 32'h7FC00000);
      rreg(8'h30, 32'h00000000);
   endtask
   task automatic t_spd;
      ent(8'h01, 32'h4003FF70, 32'h00000000);
      run(8'h01);
      cyc(1);
      #1;
      chk({dir, spd}, 17'h10064);
      cyc(20);
      #1;
      chk({act, spd}, 24'h010090);
      halt(1'b1);
   endtask
   task automatic t_trq;
      ent(8'h02, 32'h40050200, 32'h00000000);
      run(8'h02);
      jam <= 1'b1;
      cyc(1);
      #1;
      chk({dir, spd}, 17'h00200);
      cyc(10);
      #1;
      chk({ao, ad, spd}, 18'h00200);
      jam <= 1'b0;
      halt(1'b0);
   endtask
   task automatic t_man;
      ent(8'h03, 32'h7FD00064, 32'h00000080);
      ent(8'h04, 32'h40000064, 32'h00000100);
      run(8'h03);
      wrdy(1'b1);
      chk(busy, 1'b1);
      sl <= 1'b1;
      wrdy(1'b0);
      chk(act, 8'h04);
      @(posedge clk);
      sl <= 1'b0;
      wrdy(1'b1);
      chk({busy, pos}, 25'h0000100);
      sel <= 8'h03;
      sl <= 1'b1;
      wrdy(1'b0);
      chk(act, 8'h03);
      @(posedge clk);
      sl <= 1'b0;
      wrdy(1'b1);
   endtask
   task automatic t_alm;
      ent(8'h05, 32'h40020040, 32'h00000000);
      run(8'h05);
      jam <= 1'b1;
      cyc(10);
      #1;
      chk({ao, rdy, busy, spd}, 19'h40000);
      jam <= 1'b0;
      wreg(8'h00, 32'h00000001);
      wrdy(1'b1);
      chk(ao, 1'b0);
   endtask
   // Reset, then the scenarios in order.
   initial begin
      cyc(10);
      rst <= 1'b0;
      wrdy(1'b1);
      t_def();
      t_spd();
      t_trq();
      t_man();
      t_alm();
      test_done();
   end
endmodule
`default_nettype wire
